// *** frds_pkg.sv ***
// Constants, types and reset values of the fault retry/delay sequencer.
// Assumes a single 10 MHz clock and an AXI4-Lite master with 32-bit data.
package frds_pkg;
  localparam logic [7:0] FRDS_RESP_OFS = 8'h00;
  localparam logic [7:0] FRDS_UNIT_OFS = 8'h04;
  localparam logic [7:0] FRDS_CMD_OFS = 8'h08;
  localparam logic [7:0] FRDS_STAT_OFS = 8'h0c;
  localparam logic [7:0] FRDS_IST_OFS = 8'h10;
  localparam logic [7:0] FRDS_IMSK_OFS = 8'h14;
  localparam logic [7:0] FRDS_RESP_RST = 8'h80;
  localparam logic [15:0] FRDS_UNIT_RST = 16'h000a;
  localparam int FRDS_MODE_HI = 7;
  localparam int FRDS_MODE_LO = 6;
  localparam int FRDS_RTRY_HI = 5;
  localparam int FRDS_RTRY_LO = 3;
  localparam int FRDS_DLY_HI = 2;
  localparam int FRDS_DLY_LO = 0;
  localparam logic [1:0] FRDS_MODE_IGNORE = 2'h0;
  localparam logic [1:0] FRDS_MODE_CONT = 2'h1;
  localparam logic [1:0] FRDS_MODE_SHUT = 2'h2;
  localparam logic [1:0] FRDS_MODE_HOLD = 2'h3;
  localparam logic [2:0] FRDS_RTRY_NONE = 3'h0;
  localparam logic [2:0] FRDS_RTRY_CONT = 3'h7;
  localparam int FRDS_CMD_CLR = 0;
  localparam int FRDS_CMD_ON = 1;
  localparam int FRDS_EV_SHUT = 0;
  localparam int FRDS_EV_TRY = 1;
  localparam int FRDS_EV_LATCH = 2;
  localparam logic [1:0] FRDS_OKAY = 2'h0;
  localparam logic [1:0] FRDS_SLVERR = 2'h2;

  typedef enum logic [6:0] {
    FRDS_RUN = 7'h01,
    FRDS_GRACE = 7'h02,
    FRDS_HOLD = 7'h04,
    FRDS_WAIT = 7'h08,
    FRDS_PROBE = 7'h10,
    FRDS_LATCH = 7'h20,
    FRDS_OFF = 7'h40
  } frds_state_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } frds_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } frds_axi_rsp_t;

  typedef struct packed {
    frds_state_t st;
    logic [7:0] resp;
    logic [15:0] unit;
    logic on;
    logic [2:0] ist;
    logic [2:0] imsk;
    logic [15:0] ucnt;
    logic [7:0] ncnt;
    logic [2:0] tries;
    logic failed;
    logic out_en;
    logic irq;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } frds_regs_t;

  localparam frds_regs_t FRDS_REGS_RST = '{
    st: FRDS_RUN, resp: FRDS_RESP_RST, unit: FRDS_UNIT_RST, on: 1'b1,
    out_en: 1'b1, awready: 1'b1, wready: 1'b1, arready: 1'b1,
    default: '0};
endpackage

// *** frds_seq.sv ***
// Fault retry/delay sequencer with its AXI4-Lite register slave.
// Assumes fault inputs synchronous to sys_clk and a compliant bus master.
`timescale 1ns/1ns
module frds_seq (
  // Clock, reset and clock enable.
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // Register bus.
  input wire frds_pkg::frds_axi_req_t s_axi_req,
  output frds_pkg::frds_axi_rsp_t s_axi_rsp,
  // Fault inputs.
  input wire logic ov_fault,
  input wire logic other_fault,
  // Converter enable and interrupt.
  output logic out_en,
  output logic irq
);
  frds_pkg::frds_regs_t r_ff;
  frds_pkg::frds_regs_t nxt_r;
  logic tick;
  logic done;
  logic [7:0] span;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic clr;
    logic shut;
    logic attempt;
    logic [2:0] ev;
    logic [2:0] w1c;
    logic [1:0] mode;
    logic [2:0] rtry;
    clr = 1'b0;
    shut = 1'b0;
    attempt = 1'b0;
    ev = 3'h0;
    w1c = 3'h0;
    nxt_r = r_ff;
    mode = r_ff.resp[frds_pkg::FRDS_MODE_HI:frds_pkg::FRDS_MODE_LO];
    rtry = r_ff.resp[frds_pkg::FRDS_RTRY_HI:frds_pkg::FRDS_RTRY_LO];

    // Write address and data are taken independently, in either order.
    if (s_axi_req.awvalid && r_ff.awready) begin
      nxt_r.awready = 1'b0;
      nxt_r.aw_got = 1'b1;
      nxt_r.awaddr = s_axi_req.awaddr[7:0];
    end
    if (s_axi_req.wvalid && r_ff.wready) begin
      nxt_r.wready = 1'b0;
      nxt_r.w_got = 1'b1;
      nxt_r.wdata = s_axi_req.wdata;
      nxt_r.wstrb = s_axi_req.wstrb;
    end
    if (r_ff.aw_got && r_ff.w_got && !r_ff.bvalid) begin
      nxt_r.aw_got = 1'b0;
      nxt_r.w_got = 1'b0;
      nxt_r.bvalid = 1'b1;
      nxt_r.bresp = frds_pkg::FRDS_OKAY;
      case (r_ff.awaddr)
        frds_pkg::FRDS_RESP_OFS: begin
          if (r_ff.wstrb[0]) nxt_r.resp = r_ff.wdata[7:0];
        end
        frds_pkg::FRDS_UNIT_OFS: begin
          if (r_ff.wstrb[0]) nxt_r.unit[7:0] = r_ff.wdata[7:0];
          if (r_ff.wstrb[1]) nxt_r.unit[15:8] = r_ff.wdata[15:8];
        end
        frds_pkg::FRDS_CMD_OFS: begin
          if (r_ff.wstrb[0]) begin
            nxt_r.on = r_ff.wdata[frds_pkg::FRDS_CMD_ON];
            clr = r_ff.wdata[frds_pkg::FRDS_CMD_CLR];
          end
        end
        frds_pkg::FRDS_IST_OFS: begin
          if (r_ff.wstrb[0]) w1c = r_ff.wdata[2:0];
        end
        frds_pkg::FRDS_IMSK_OFS: begin
          if (r_ff.wstrb[0]) nxt_r.imsk = r_ff.wdata[2:0];
        end
        frds_pkg::FRDS_STAT_OFS: begin
        end
        default: begin
          nxt_r.bresp = frds_pkg::FRDS_SLVERR;
        end
      endcase
    end
    if (r_ff.bvalid && s_axi_req.bready) begin
      nxt_r.bvalid = 1'b0;
      nxt_r.awready = 1'b1;
      nxt_r.wready = 1'b1;
    end

    // Reads answer one cycle after the address is taken.
    if (s_axi_req.arvalid && r_ff.arready) begin
      nxt_r.arready = 1'b0;
      nxt_r.rvalid = 1'b1;
      nxt_r.rresp = frds_pkg::FRDS_OKAY;
      case (s_axi_req.araddr[7:0])
        frds_pkg::FRDS_RESP_OFS: nxt_r.rdata = {24'h000000, r_ff.resp};
        frds_pkg::FRDS_UNIT_OFS: nxt_r.rdata = {16'h0000, r_ff.unit};
        frds_pkg::FRDS_CMD_OFS: nxt_r.rdata = {30'h00000000, r_ff.on, 1'b0};
        frds_pkg::FRDS_STAT_OFS: begin
          nxt_r.rdata = {17'h00000, r_ff.failed, r_ff.on, r_ff.out_en, 1'b0,
                         r_ff.tries, 1'b0, r_ff.st};
        end
        frds_pkg::FRDS_IST_OFS: nxt_r.rdata = {29'h00000000, r_ff.ist};
        frds_pkg::FRDS_IMSK_OFS: nxt_r.rdata = {29'h00000000, r_ff.imsk};
        default: begin
          nxt_r.rdata = 32'h00000000;
          nxt_r.rresp = frds_pkg::FRDS_SLVERR;
        end
      endcase
    end
    if (r_ff.rvalid && s_axi_req.rready) begin
      nxt_r.rvalid = 1'b0;
      nxt_r.arready = 1'b1;
    end

    // Delay timer: a unit prescaler feeding a two-power unit count.
    tick = ({1'b0, r_ff.ucnt} + 17'h00001) >= {1'b0, r_ff.unit};
    span = 8'h01 << r_ff.resp[frds_pkg::FRDS_DLY_HI:frds_pkg::FRDS_DLY_LO];
    done = tick && (r_ff.ncnt == span - 8'h01);
    if (r_ff.st inside {frds_pkg::FRDS_GRACE, frds_pkg::FRDS_WAIT,
                        frds_pkg::FRDS_PROBE}) begin
      if (tick) begin
        nxt_r.ucnt = 16'h0000;
        nxt_r.ncnt = r_ff.ncnt + 8'h01;
      end else begin
        nxt_r.ucnt = r_ff.ucnt + 16'h0001;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    case (r_ff.st)
      frds_pkg::FRDS_RUN: begin
        if (ov_fault) begin
          case (mode)
            frds_pkg::FRDS_MODE_IGNORE: begin
            end
            frds_pkg::FRDS_MODE_CONT: begin
              nxt_r.st = frds_pkg::FRDS_GRACE;
              nxt_r.ucnt = 16'h0000;
              nxt_r.ncnt = 8'h00;
            end
            frds_pkg::FRDS_MODE_SHUT: shut = 1'b1;
            frds_pkg::FRDS_MODE_HOLD: begin
              nxt_r.st = frds_pkg::FRDS_HOLD;
              nxt_r.out_en = 1'b0;
              ev[frds_pkg::FRDS_EV_SHUT] = 1'b1;
            end
            default: shut = 1'b1;
          endcase
        end
      end
      frds_pkg::FRDS_GRACE: begin
        if (!ov_fault) nxt_r.st = frds_pkg::FRDS_RUN;
        else if (done) shut = 1'b1;
      end
      frds_pkg::FRDS_HOLD: begin
        if (!ov_fault) begin
          nxt_r.st = frds_pkg::FRDS_RUN;
          nxt_r.out_en = 1'b1;
        end
      end
      frds_pkg::FRDS_WAIT: begin
        if (done) attempt = 1'b1;
      end
      frds_pkg::FRDS_PROBE: begin
        if (ov_fault) begin
          nxt_r.failed = 1'b1;
          nxt_r.out_en = 1'b0;
        end
        if (done) begin
          if (!(r_ff.failed || ov_fault)) begin
            nxt_r.st = frds_pkg::FRDS_RUN;
            nxt_r.tries = 3'h0;
          end else if (rtry == frds_pkg::FRDS_RTRY_CONT || r_ff.tries < rtry)
            attempt = 1'b1;
          else begin
            nxt_r.st = frds_pkg::FRDS_LATCH;
            nxt_r.out_en = 1'b0;
          end
        end
      end
      frds_pkg::FRDS_LATCH: begin
        nxt_r.out_en = 1'b0;
        if (clr) begin
          nxt_r.st = frds_pkg::FRDS_RUN;
          nxt_r.out_en = 1'b1;
        end
      end
      frds_pkg::FRDS_OFF: begin
        nxt_r.out_en = 1'b0;
        if (r_ff.on) begin
          nxt_r.st = frds_pkg::FRDS_RUN;
          nxt_r.out_en = 1'b1;
        end
      end
      default: begin
        nxt_r.st = frds_pkg::FRDS_OFF;
        nxt_r.out_en = 1'b0;
      end
    endcase

    if (shut) begin
      nxt_r.out_en = 1'b0;
      nxt_r.tries = 3'h0;
      nxt_r.ucnt = 16'h0000;
      nxt_r.ncnt = 8'h00;
      ev[frds_pkg::FRDS_EV_SHUT] = 1'b1;
      if (rtry == frds_pkg::FRDS_RTRY_NONE) nxt_r.st = frds_pkg::FRDS_LATCH;
      else nxt_r.st = frds_pkg::FRDS_WAIT;
    end
    if (attempt) begin
      nxt_r.st = frds_pkg::FRDS_PROBE;
      nxt_r.out_en = 1'b1;
      nxt_r.failed = 1'b0;
      nxt_r.ucnt = 16'h0000;
      nxt_r.ncnt = 8'h00;
      if (r_ff.tries != 3'h7) nxt_r.tries = r_ff.tries + 3'h1;
      ev[frds_pkg::FRDS_EV_TRY] = 1'b1;
    end
    // A different fault during the retry sequence ends it for good.
    if (other_fault && (r_ff.st inside {frds_pkg::FRDS_WAIT,
                                        frds_pkg::FRDS_PROBE})) begin
      nxt_r.st = frds_pkg::FRDS_LATCH;
      nxt_r.out_en = 1'b0;
    end
    // Commanding the output off overrides every other outcome.
    if (!nxt_r.on) begin
      nxt_r.st = frds_pkg::FRDS_OFF;
      nxt_r.out_en = 1'b0;
      nxt_r.tries = 3'h0;
      nxt_r.failed = 1'b0;
    end
    if (nxt_r.st == frds_pkg::FRDS_LATCH && r_ff.st != frds_pkg::FRDS_LATCH)
      ev[frds_pkg::FRDS_EV_LATCH] = 1'b1;

    // New events win over a simultaneous write-one-to-clear.
    nxt_r.ist = (r_ff.ist & ~w1c) | ev;
    nxt_r.irq = |(nxt_r.ist & nxt_r.imsk);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r_ff <= frds_pkg::FRDS_REGS_RST;
    end else if (ce) begin
      r_ff <= nxt_r;
    end
  end

  assign out_en = r_ff.out_en;
  assign irq = r_ff.irq;
  assign s_axi_rsp.awready = r_ff.awready;
  assign s_axi_rsp.wready = r_ff.wready;
  assign s_axi_rsp.bvalid = r_ff.bvalid;
  assign s_axi_rsp.bresp = r_ff.bresp;
  assign s_axi_rsp.arready = r_ff.arready;
  assign s_axi_rsp.rvalid = r_ff.rvalid;
  assign s_axi_rsp.rdata = r_ff.rdata;
  assign s_axi_rsp.rresp = r_ff.rresp;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  no_retry_latch_a: assert property (
    ce && nxt_r.on && r_ff.st == frds_pkg::FRDS_RUN && ov_fault &&
    r_ff.resp[7:6] == frds_pkg::FRDS_MODE_SHUT &&
    r_ff.resp[5:3] == frds_pkg::FRDS_RTRY_NONE
    |=> r_ff.st == frds_pkg::FRDS_LATCH && !out_en)
    else $error("zero retry count did not latch off");

  exhaust_latch_a: assert property (
    ce && nxt_r.on && !other_fault && r_ff.st == frds_pkg::FRDS_PROBE &&
    done && (r_ff.failed || ov_fault) &&
    r_ff.resp[5:3] != frds_pkg::FRDS_RTRY_CONT && r_ff.tries >= r_ff.resp[5:3]
    |=> r_ff.st == frds_pkg::FRDS_LATCH)
    else $error("exhausted retries did not latch off");

  cont_retry_a: assert property (
    ce && nxt_r.on && !other_fault && r_ff.st == frds_pkg::FRDS_PROBE &&
    r_ff.resp[5:3] == frds_pkg::FRDS_RTRY_CONT
    |=> r_ff.st != frds_pkg::FRDS_LATCH)
    else $error("continuous retry stopped by itself");

  other_stop_a: assert property (
    ce && other_fault && (r_ff.st inside {frds_pkg::FRDS_WAIT,
                                          frds_pkg::FRDS_PROBE})
    |=> r_ff.st inside {frds_pkg::FRDS_LATCH, frds_pkg::FRDS_OFF})
    else $error("other fault did not stop retrying");

  grace_running_a: assert property (
    r_ff.st == frds_pkg::FRDS_GRACE |-> out_en)
    else $error("output dropped during continue time");

  attempt_spacing_a: assert property (
    r_ff.st != frds_pkg::FRDS_PROBE ##1 r_ff.st == frds_pkg::FRDS_PROBE
    |-> $past(done) && out_en)
    else $error("restart attempt began before delay end");

  ignore_fault_a: assert property (
    ce && r_ff.st == frds_pkg::FRDS_RUN && ov_fault &&
    r_ff.resp[7:6] == frds_pkg::FRDS_MODE_IGNORE
    |=> r_ff.st inside {frds_pkg::FRDS_RUN, frds_pkg::FRDS_OFF})
    else $error("ignored fault changed state");

  disable_now_a: assert property (
    ce && r_ff.st == frds_pkg::FRDS_RUN && ov_fault &&
    r_ff.resp[7:6] == frds_pkg::FRDS_MODE_SHUT |=> !out_en)
    else $error("output not disabled at once");

  hold_release_a: assert property (
    ce && nxt_r.on && r_ff.st == frds_pkg::FRDS_HOLD && !ov_fault
    |-> !out_en ##1 out_en && r_ff.st == frds_pkg::FRDS_RUN)
    else $error("hold mode did not release with fault gone");

  retry_again_a: assert property (
    ce && nxt_r.on && !other_fault && r_ff.st == frds_pkg::FRDS_PROBE &&
    done && (r_ff.failed || ov_fault) &&
    r_ff.resp[5:3] != frds_pkg::FRDS_RTRY_CONT && r_ff.tries < r_ff.resp[5:3]
    |=> r_ff.st == frds_pkg::FRDS_PROBE &&
        r_ff.tries == $past(r_ff.tries) + 3'h1)
    else $error("failed attempt with tries left did not retry");

  delay_seven_a: assert property (
    r_ff.resp[2:0] == 3'h7 |-> span == 8'h80)
    else $error("delay field seven is not 128 units");

  delay_four_a: assert property (
    r_ff.resp[2:0] == 3'h2 |-> span == 8'h04)
    else $error("delay field two is not four units");

  grace_end_a: assert property (
    ce && nxt_r.on && r_ff.st == frds_pkg::FRDS_GRACE && ov_fault && done
    |=> !out_en)
    else $error("fault outlasting the delay did not shut down");

  freeze_state_a: assert property (
    !ce |=> $stable(r_ff))
    else $error("state moved with clock enable low");

  irq_level_a: assert property (
    irq == |(r_ff.ist & r_ff.imsk))
    else $error("interrupt does not follow unmasked status");
endmodule // frds_seq

// *** frds_plant.sv ***
// Converter plant model that drives the over-voltage fault input.
// Assumes the bench drives ov_arm and ov_force from sys_clk.
`timescale 1ns/1ns
module frds_plant (
  // Clock.
  input wire logic sys_clk,
  // Converter side.
  input wire logic out_en,
  input wire logic ov_arm,
  input wire logic ov_force,
  output logic ov_fault
);
  logic en_ff;
  // The output voltage follows the enable one cycle late.
  always_ff @(posedge sys_clk) begin
    en_ff <= out_en;
  end
  assign ov_fault = ov_force | (ov_arm & en_ff);
endmodule // frds_plant

// *** frds_seq_test.sv ***
// Self-checking bench for the fault retry/delay sequencer.
// Assumes frds_pkg, frds_seq and the plant model in frds_plant.sv.
`timescale 1ns/1ns
module frds_seq_test;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  frds_pkg::frds_axi_req_t req = '0;
  frds_pkg::frds_axi_rsp_t rsp;
  logic ov_fault;
  logic ov_arm = 1'b0;
  logic ov_force = 1'b0;
  logic other_fault = 1'b0;
  logic out_en;
  logic irq;
  logic en_q = 1'b1;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int rises = 0;
  int t_last = 0;
  int t_prev = 0;

  always #50 sys_clk = ~sys_clk;

  frds_seq uut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .s_axi_req(req),
    .s_axi_rsp(rsp), .ov_fault(ov_fault), .other_fault(other_fault),
    .out_en(out_en), .irq(irq));
  frds_plant plant (.sys_clk(sys_clk), .out_en(out_en), .ov_arm(ov_arm),
    .ov_force(ov_force), .ov_fault(ov_fault));

  // Each restart attempt shows as a rising edge of the output enable.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    en_q <= out_en;
    if (out_en === 1'b1 && en_q === 1'b0) begin
      rises <= rises + 1;
      t_prev <= t_last;
      t_last <= cyc;
    end
  end

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge sys_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= {24'h0, a};
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (!aw && rsp.awready === 1'b1) begin
        aw = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w && rsp.wready === 1'b1) begin
        w = 1'b1;
        req.wvalid <= 1'b0;
      end
      if (rsp.bvalid === 1'b1) begin
        chk("bresp", {30'h0, rsp.bresp}, {30'h0, frds_pkg::FRDS_OKAY});
        break;
      end
    end
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    d = 32'h0;
    r = 2'h3;
    @(posedge sys_clk);
    req.arvalid <= 1'b1;
    req.araddr <= {24'h0, a};
    req.rready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (rsp.arready === 1'b1) begin
        req.arvalid <= 1'b0;
      end
      if (rsp.rvalid === 1'b1) begin
        d = rsp.rdata;
        r = rsp.rresp;
        break;
      end
    end
    req.rready <= 1'b0;
  endtask

  // Leaves the latched state, clears status and lets the output settle.
  task automatic recover();
    wr(frds_pkg::FRDS_CMD_OFS, 32'h3);
    wr(frds_pkg::FRDS_IST_OFS, 32'h7);
    repeat (4) @(posedge sys_clk);
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rd(frds_pkg::FRDS_RESP_OFS, d, r);
    chk("resp", d, 32'h80);
    rd(frds_pkg::FRDS_UNIT_OFS, d, r);
    chk("unit", d, 32'h0a);
    chk("rresp", {30'h0, r}, {30'h0, frds_pkg::FRDS_OKAY});
    rd(8'h40, d, r);
    chk("unmapped", {r, d[29:0]}, {frds_pkg::FRDS_SLVERR, 30'h0});
    $display("reset test done");
  endtask

  task automatic t_retry();
    int base;
    wr(frds_pkg::FRDS_UNIT_OFS, 32'h4);
    for (int n = 0; n < 7; n++) begin
      wr(frds_pkg::FRDS_IMSK_OFS, (n == 0) ? 32'h0 : 32'h4);
      wr(frds_pkg::FRDS_RESP_OFS, {24'h0, 2'b10, 3'(n), 3'h1});
      base = rises;
      ov_arm <= 1'b1;
      repeat (200) @(posedge sys_clk);
      chk("restarts", rises - base, n);
      chk("latched off", {31'h0, out_en}, 32'h0);
      chk("irq", {31'h0, irq}, (n == 0) ? 32'h0 : 32'h1);
      if (n >= 2) begin
        chk("spacing", t_last - t_prev, 32'h8);
      end
      ov_arm <= 1'b0;
      recover();
      chk("cleared", {30'h0, irq, out_en}, 32'h1);
    end
    $display("retry test done");
  endtask

  task automatic t_cont();
    int base;
    wr(frds_pkg::FRDS_RESP_OFS, 32'hb9);
    base = rises;
    ov_arm <= 1'b1;
    repeat (150) @(posedge sys_clk);
    chk("endless", 32'(rises - base > 6), 32'h1);
    other_fault <= 1'b1;
    repeat (20) @(posedge sys_clk);
    other_fault <= 1'b0;
    base = rises;
    repeat (50) @(posedge sys_clk);
    chk("other stop", {out_en, 31'(rises - base)}, 32'h0);
    recover();
    repeat (40) @(posedge sys_clk);
    wr(frds_pkg::FRDS_CMD_OFS, 32'h0);
    base = rises;
    repeat (100) @(posedge sys_clk);
    chk("cmd off", {out_en, 31'(rises - base)}, 32'h0);
    ov_arm <= 1'b0;
    wr(frds_pkg::FRDS_CMD_OFS, 32'h2);
    recover();
    chk("cmd on", {31'h0, out_en}, 32'h1);
    $display("continuous test done");
  endtask

  // Returns the cycles from fault onset until the output goes off.
  task automatic grace(input logic [2:0] n, output int t);
    wr(frds_pkg::FRDS_RESP_OFS, {24'h0, 2'b01, 3'h0, n});
    @(posedge sys_clk);
    ov_force <= 1'b1;
    t = 0;
    forever begin
      @(posedge sys_clk);
      if (out_en === 1'b0) break;
      t++;
    end
    ov_force <= 1'b0;
    recover();
  endtask

  task automatic t_grace();
    int t0;
    int t;
    wr(frds_pkg::FRDS_UNIT_OFS, 32'h1);
    grace(3'h0, t0);
    for (int n = 1; n < 8; n++) begin
      grace(3'(n), t);
      chk("delay", t - t0, (1 << n) - 1);
    end
    wr(frds_pkg::FRDS_UNIT_OFS, 32'h3);
    grace(3'h0, t0);
    grace(3'h2, t);
    chk("unit len", t - t0, 32'h9);
    wr(frds_pkg::FRDS_RESP_OFS, 32'h43);
    ov_force <= 1'b1;
    repeat (5) @(posedge sys_clk);
    ov_force <= 1'b0;
    repeat (40) @(posedge sys_clk);
    chk("brief fault", {31'h0, out_en}, 32'h1);
    $display("delay test done");
  endtask

  task automatic t_modes();
    int lows;
    logic [31:0] d;
    logic [1:0] r;
    lows = 0;
    wr(frds_pkg::FRDS_RESP_OFS, 32'h0);
    ov_force <= 1'b1;
    repeat (30) begin
      @(posedge sys_clk);
      lows += (out_en !== 1'b1);
    end
    chk("ignore", lows, 32'h0);
    ov_force <= 1'b0;
    wr(frds_pkg::FRDS_RESP_OFS, 32'hc0);
    ov_force <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk("hold off", {31'h0, out_en}, 32'h0);
    ov_force <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("hold on", {31'h0, out_en}, 32'h1);
    rd(frds_pkg::FRDS_IST_OFS, d, r);
    chk("shut event", d, 32'h1);
    wr(frds_pkg::FRDS_IST_OFS, 32'h1);
    rd(frds_pkg::FRDS_IST_OFS, d, r);
    chk("event cleared", d, 32'h0);
    $display("mode test done");
  endtask

  // Lowering the clock enable must hold every state bit where it is.
  task automatic t_freeze();
    wr(frds_pkg::FRDS_RESP_OFS, 32'hc0);
    ce <= 1'b0;
    ov_force <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk("frozen", {31'h0, out_en}, 32'h1);
    ce <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("thawed", {31'h0, out_en}, 32'h0);
    ov_force <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("thaw release", {31'h0, out_en}, 32'h1);
    $display("enable test done");
  endtask

  // A reset in mid-run must bring back every reset value.
  task automatic t_rerst();
    logic [31:0] d;
    logic [1:0] r;
    wr(frds_pkg::FRDS_RESP_OFS, 32'h3f);
    wr(frds_pkg::FRDS_CMD_OFS, 32'h0);
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    chk("out after reset", {30'h0, irq, out_en}, 32'h1);
    rd(frds_pkg::FRDS_RESP_OFS, d, r);
    chk("resp after reset", d, {24'h0, frds_pkg::FRDS_RESP_RST});
    rd(frds_pkg::FRDS_CMD_OFS, d, r);
    chk("on after reset", d, 32'h2);
    $display("second reset test done");
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge sys_clk);
    miscompares++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_retry();
    t_cont();
    t_grace();
    t_modes();
    t_freeze();
    t_rerst();
    end_sim();
  end
endmodule // frds_seq_test
